// ### verilog/asp_aux_spi_ois_gyro_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module asp_aux_spi_ois_gyro_port
   import asp_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        prim_req,
   input  wire logic        prim_we,
   input  wire logic [6:0]  prim_addr,
   input  wire logic [7:0]  prim_wdata,
   output logic      [7:0]  prim_rdata,
   output logic             prim_rvalid,
   input  wire logic [47:0] prim_gyro_data,
   input  wire logic [7:0]  prim_status,
   input  wire logic [15:0] fifo_data,
   input  wire logic [47:0] ois_gyro_data,
   input  wire logic        ois_gyro_valid,
   input  wire logic        gyro_settling,
   input  wire logic        aux_serial_clock_pin,
   input  wire logic        aux_cs_n_pin,
   input  wire logic        aux_serial_data_pin_in,
   output logic             aux_serial_data_pin_out,
   output logic             aux_serial_data_pin_oe,
   output logic             aux_mode_active,
   output logic             gyro_new_sample_flag
);

   asp_top_state_type st_ff;
   asp_top_state_type nxt_st;
   logic              settle_meta_ff;
   logic              settle_ff;
   logic [6:0]        aux_addr;
   logic [6:0]        aux_wr_addr;
   logic [7:0]        aux_wr_data;
   logic              aux_wr_pulse;
   logic              aux_rd_pulse;
   logic [7:0]        aux_rd_data;
   logic              capture;
   logic              clear;
   logic [15:0]       word;

   // ****************************************************************
   // Address decoding
   // ****************************************************************
   function automatic logic is_gyro_out(input logic [6:0] a);
      return (a >= `ASP_ADDR_GYRO_FIRST) && (a <= `ASP_ADDR_GYRO_LAST);
   endfunction

   function automatic logic is_fifo_out(input logic [6:0] a);
      return (a == `ASP_ADDR_FIFO_OUT_LO) || (a == `ASP_ADDR_FIFO_OUT_HI);
   endfunction

   function automatic logic [2:0] gyro_index(input logic [6:0] a);
      logic [6:0] d;
      d = 7'(a - `ASP_ADDR_GYRO_FIRST);
      return d[2:0];
   endfunction

   function automatic logic [7:0] ctrl_byte(input asp_ctrl_type c);
      logic [7:0] b;
      b = `ASP_RST_BYTE;
      b[`ASP_CTRL_SWAP_BIT]      = c.byte_swap;
      b[`ASP_CTRL_READ_EN_BIT]   = c.read_en;
      b[`ASP_CTRL_HIGH_RATE_BIT] = c.high_rate_en;
      return b;
   endfunction

   function automatic logic prim_writable(input logic [6:0] a);
      return (a != `ASP_ADDR_AUX_CONTROL) && (a != `ASP_ADDR_AUX_STATUS) &&
             !is_gyro_out(a) && !is_fifo_out(a);
   endfunction

   // ****************************************************************
   // Read paths, one per port, evaluated side by side
   // ****************************************************************
   function automatic logic [7:0] prim_read(input logic [6:0] a);
      logic [7:0] b;
      b = st_ff.regs[a];
      if (a == `ASP_ADDR_AUX_CONTROL)
         b = ctrl_byte(st_ff.ctrl);
      else if (a == `ASP_ADDR_AUX_STATUS)
         b = prim_status;
      else if (is_gyro_out(a))
         b = prim_gyro_data[8*gyro_index(a) +: 8];
      else if (a == `ASP_ADDR_FIFO_OUT_LO)
         b = fifo_data[7:0];
      else if (a == `ASP_ADDR_FIFO_OUT_HI)
         b = fifo_data[15:8];
      return b;
   endfunction

   function automatic logic [7:0] aux_read(input logic [6:0] a);
      logic [7:0] b;
      b = st_ff.regs[a];
      if (a == `ASP_ADDR_AUX_CONTROL)
         b = ctrl_byte(st_ff.ctrl);
      else if (a == `ASP_ADDR_AUX_STATUS)
      begin
         b = `ASP_RST_BYTE;
         b[`ASP_STAT_SETTLING_BIT] = settle_ff;
         b[`ASP_STAT_NEW_BIT]      = st_ff.new_flag;
      end
      else if (is_gyro_out(a))
         b = st_ff.gyro[gyro_index(a)];
      else if (is_fifo_out(a))
         b = `ASP_RST_BYTE;
      return b;
   endfunction

   // Process form so that register contents, not only the address, retrigger it
   always_comb
      aux_rd_data = aux_read(aux_addr);

   // ****************************************************************
   // Aux serial engine
   // ****************************************************************
   asp_aux_spi_slave u_aux_spi_slave (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .sclk_pin (aux_serial_clock_pin),
      .cs_n_pin (aux_cs_n_pin),
      .sdio_in  (aux_serial_data_pin_in),
      .read_en  (st_ff.ctrl.read_en),
      .rd_data  (aux_rd_data),
      .sdio_out (aux_serial_data_pin_out),
      .sdio_oe  (aux_serial_data_pin_oe),
      .addr     (aux_addr),
      .wr_addr  (aux_wr_addr),
      .wr_data  (aux_wr_data),
      .wr_pulse (aux_wr_pulse),
      .rd_pulse (aux_rd_pulse)
   );

   // ****************************************************************
   // Settling level from the gyro chain's own domain
   // ****************************************************************
   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         settle_meta_ff <= 1'b0;
         settle_ff      <= 1'b0;
      end
      else
      begin
         settle_meta_ff <= gyro_settling;
         settle_ff      <= settle_meta_ff;
      end
   end

   // ****************************************************************
   // Register file and aux gyro chain
   // ****************************************************************
   always_comb
   begin
      nxt_st             = st_ff;
      word               = 16'h0000;
      nxt_st.prim_rvalid = prim_req & ~prim_we;
      if (prim_req && !prim_we)
         nxt_st.prim_rdata = prim_read(prim_addr);
      if (prim_req && prim_we && prim_writable(prim_addr))
         nxt_st.regs[prim_addr] = prim_wdata;
      if (aux_wr_pulse && (aux_wr_addr == `ASP_ADDR_AUX_CONTROL))
      begin
         nxt_st.ctrl.byte_swap    = aux_wr_data[`ASP_CTRL_SWAP_BIT];
         nxt_st.ctrl.read_en      = aux_wr_data[`ASP_CTRL_READ_EN_BIT];
         nxt_st.ctrl.high_rate_en = aux_wr_data[`ASP_CTRL_HIGH_RATE_BIT];
      end
      nxt_st.mode_active = nxt_st.ctrl.read_en & nxt_st.ctrl.high_rate_en;
      capture = st_ff.mode_active & ois_gyro_valid;
      if (capture)
      begin
         for (int i = 0; i < 3; i++)
         begin
            word = ois_gyro_data[16*i +: 16];
            if (st_ff.ctrl.byte_swap)
            begin
               nxt_st.gyro[2*i]   = word[15:8];
               nxt_st.gyro[2*i+1] = word[7:0];
            end
            else
            begin
               nxt_st.gyro[2*i]   = word[7:0];
               nxt_st.gyro[2*i+1] = word[15:8];
            end
         end
      end
      // Odd offsets are the high parts while byte_swap is clear, the low parts while it is set
      clear = aux_rd_pulse & is_gyro_out(aux_addr) & aux_addr[0];
      nxt_st.new_flag = capture | (st_ff.new_flag & ~clear);
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign prim_rdata           = st_ff.prim_rdata;
   assign prim_rvalid          = st_ff.prim_rvalid;
   assign aux_mode_active      = st_ff.mode_active;
   assign gyro_new_sample_flag = st_ff.new_flag;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_mode_on;
      @(posedge core_clk) disable iff (!arst_n)
      aux_mode_active == (st_ff.ctrl.read_en && st_ff.ctrl.high_rate_en);
   endproperty
   a_mode_on: assert property (p_mode_on)
      else $error("aux mode not tied to both enable bits");

   property p_prim_ctrl_ro;
      @(posedge core_clk) disable iff (!arst_n)
      (prim_req && prim_we && prim_addr == `ASP_ADDR_AUX_CONTROL && !aux_wr_pulse)
         |=> $stable(st_ff.ctrl);
   endproperty
   a_prim_ctrl_ro: assert property (p_prim_ctrl_ro)
      else $error("primary write changed aux control");

   property p_aux_wr_ignored;
      @(posedge core_clk) disable iff (!arst_n)
      (aux_wr_pulse && !prim_req) |=> $stable(st_ff.regs);
   endproperty
   a_aux_wr_ignored: assert property (p_aux_wr_ignored)
      else $error("aux write altered a shared register");

   property p_flag_set;
      @(posedge core_clk) disable iff (!arst_n)
      (aux_mode_active && ois_gyro_valid) |=> gyro_new_sample_flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("new sample flag not set");

   property p_flag_clear;
      @(posedge core_clk) disable iff (!arst_n)
      (aux_rd_pulse && is_gyro_out(aux_addr) && aux_addr[0] && !ois_gyro_valid)
         |=> !gyro_new_sample_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("new sample flag not cleared on high byte read");

   property p_swap;
      @(posedge core_clk) disable iff (!arst_n)
      (aux_mode_active && ois_gyro_valid && st_ff.ctrl.byte_swap)
         |=> (st_ff.gyro[0] == $past(ois_gyro_data[15:8]));
   endproperty
   a_swap: assert property (p_swap)
      else $error("aux gyro bytes not swapped");

   property p_fifo_hidden;
      @(posedge core_clk) disable iff (!arst_n)
      is_fifo_out(aux_addr) |-> (aux_rd_data == `ASP_RST_BYTE);
   endproperty
   a_fifo_hidden: assert property (p_fifo_hidden)
      else $error("fifo data visible on aux port");

   property p_prim_gyro;
      @(posedge core_clk) disable iff (!arst_n)
      (prim_req && !prim_we && prim_addr == `ASP_ADDR_GYRO_FIRST)
         |=> prim_rvalid && (prim_rdata == $past(prim_gyro_data[7:0]));
   endproperty
   a_prim_gyro: assert property (p_prim_gyro)
      else $error("primary gyro read wrong");

   property p_aux_status;
      @(posedge core_clk) disable iff (!arst_n)
      (aux_addr == `ASP_ADDR_AUX_STATUS) |->
         (aux_rd_data == {5'h00, settle_ff, st_ff.new_flag, 1'b0});
   endproperty
   a_aux_status: assert property (p_aux_status)
      else $error("aux status byte wrong");

   c_mode: cover property (@(posedge core_clk) disable iff (!arst_n) $rose(aux_mode_active));
   c_sample: cover property (@(posedge core_clk) disable iff (!arst_n)
      gyro_new_sample_flag ##1 !gyro_new_sample_flag);
   c_both: cover property (@(posedge core_clk) disable iff (!arst_n) prim_rvalid && aux_rd_pulse);

endmodule // asp_aux_spi_ois_gyro_port
`default_nettype wire

// ### verilog/asp_cfg.svh
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ASP_ADDR_AUX_STATUS    7'h1e
`define ASP_ADDR_GYRO_FIRST    7'h22
`define ASP_ADDR_GYRO_LAST     7'h27
`define ASP_ADDR_FIFO_OUT_LO   7'h3e
`define ASP_ADDR_FIFO_OUT_HI   7'h3f
`define ASP_ADDR_AUX_CONTROL   7'h70

// ****************************************************************
// Field positions
// ****************************************************************
`define ASP_CTRL_SWAP_BIT      7
`define ASP_CTRL_READ_EN_BIT   5
`define ASP_CTRL_HIGH_RATE_BIT 0
`define ASP_STAT_SETTLING_BIT  2
`define ASP_STAT_NEW_BIT       1

// ****************************************************************
// Reset values
// ****************************************************************
`define ASP_RST_BYTE           8'h00

`endif

// ### verilog/asp_pkg.sv
package asp_pkg;

   typedef struct packed {
      logic byte_swap;
      logic read_en;
      logic high_rate_en;
   } asp_ctrl_type;

   typedef struct packed {
      logic       sclk_meta;
      logic       sclk_sync;
      logic       sclk_last;
      logic       cs_meta;
      logic       cs_sync;
      logic       sd_meta;
      logic       sd_sync;
      logic [3:0] cnt;
      logic       rw;
      logic [6:0] addr;
      logic [7:0] rx;
      logic [7:0] tx;
      logic       sdo;
      logic       oe;
      logic [6:0] wr_addr;
      logic [7:0] wr_data;
      logic       wr_pulse;
      logic       rd_pulse;
   } asp_slave_state_type;

   typedef struct packed {
      asp_ctrl_type       ctrl;
      logic               mode_active;
      logic               new_flag;
      logic [5:0][7:0]    gyro;
      logic [127:0][7:0]  regs;
      logic [7:0]         prim_rdata;
      logic               prim_rvalid;
   } asp_top_state_type;

endpackage

// ### verilog/asp_aux_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
module asp_aux_spi_slave
   import asp_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   input  wire logic       sclk_pin,
   input  wire logic       cs_n_pin,
   input  wire logic       sdio_in,
   input  wire logic       read_en,
   input  wire logic [7:0] rd_data,
   output logic            sdio_out,
   output logic            sdio_oe,
   output logic [6:0]      addr,
   output logic [6:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            wr_pulse,
   output logic            rd_pulse
);

   asp_slave_state_type st_ff;
   asp_slave_state_type nxt_st;
   logic                rise;
   logic                fall;
   logic [7:0]          rx_shift;

   // ****************************************************************
   // Serial engine: mode 3, header of rw bit and 7 address bits
   // ****************************************************************
   always_comb
   begin
      nxt_st           = st_ff;
      nxt_st.wr_pulse  = 1'b0;
      nxt_st.rd_pulse  = 1'b0;
      nxt_st.sclk_meta = sclk_pin;
      nxt_st.sclk_sync = st_ff.sclk_meta;
      nxt_st.sclk_last = st_ff.sclk_sync;
      nxt_st.cs_meta   = cs_n_pin;
      nxt_st.cs_sync   = st_ff.cs_meta;
      nxt_st.sd_meta   = sdio_in;
      nxt_st.sd_sync   = st_ff.sd_meta;
      rise     = st_ff.sclk_sync & ~st_ff.sclk_last;
      fall     = ~st_ff.sclk_sync & st_ff.sclk_last;
      rx_shift = {st_ff.rx[6:0], st_ff.sd_sync};
      if (st_ff.cs_sync)
      begin
         nxt_st.cnt = 4'h0;
         nxt_st.rw  = 1'b0;
         nxt_st.oe  = 1'b0;
      end
      else if (rise)
      begin
         nxt_st.rx = rx_shift;
         if (st_ff.cnt == 4'h7)
         begin
            nxt_st.rw   = rx_shift[7];
            nxt_st.addr = rx_shift[6:0];
            nxt_st.cnt  = 4'h8;
         end
         else if (st_ff.cnt == 4'hf)
         begin
            // Byte done; auto-increment for multi-byte frames
            nxt_st.wr_pulse = ~st_ff.rw;
            nxt_st.wr_addr  = st_ff.addr;
            nxt_st.wr_data  = rx_shift;
            nxt_st.addr     = 7'(st_ff.addr + 7'h01);
            nxt_st.cnt      = 4'h8;
         end
         else
         begin
            nxt_st.cnt = 4'(st_ff.cnt + 4'h1);
         end
      end
      else if (fall && st_ff.cnt[3] && st_ff.rw)
      begin
         if (st_ff.cnt == 4'h8)
         begin
            nxt_st.tx       = rd_data;
            nxt_st.sdo      = rd_data[7];
            nxt_st.rd_pulse = 1'b1;
         end
         else
         begin
            nxt_st.tx  = {st_ff.tx[6:0], 1'b0};
            nxt_st.sdo = st_ff.tx[6];
         end
         // No drive unless three-wire read is on
         nxt_st.oe = read_en;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_ff           <= '0;
         st_ff.sclk_meta <= 1'b1;
         st_ff.sclk_sync <= 1'b1;
         st_ff.sclk_last <= 1'b1;
         st_ff.cs_meta   <= 1'b1;
         st_ff.cs_sync   <= 1'b1;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sdio_out = st_ff.sdo;
   assign sdio_oe  = st_ff.oe;
   assign addr     = st_ff.addr;
   assign wr_addr  = st_ff.wr_addr;
   assign wr_data  = st_ff.wr_data;
   assign wr_pulse = st_ff.wr_pulse;
   assign rd_pulse = st_ff.rd_pulse;

   // ****************************************************************
   // Checks
   // ****************************************************************
   property p_oe_in_frame;
      @(posedge core_clk) disable iff (!arst_n)
      st_ff.cs_sync |=> !sdio_oe;
   endproperty
   a_oe_in_frame: assert property (p_oe_in_frame)
      else $error("aux data driven outside frame");

   property p_addr_inc;
      @(posedge core_clk) disable iff (!arst_n)
      wr_pulse |-> (addr == 7'(wr_addr + 7'h01));
   endproperty
   a_addr_inc: assert property (p_addr_inc)
      else $error("aux address did not advance");

   c_read_byte: cover property (@(posedge core_clk) disable iff (!arst_n) rd_pulse);

endmodule // asp_aux_spi_slave
`default_nettype wire

// ### sim/asp_aux_master.sv
`timescale 1ns/1ps
`default_nettype none
module asp_aux_master
   import asp_pkg::*;
(
   input  wire logic       sd_wire,
   output logic            sclk,
   output logic            cs_n,
   output logic            sd_out,
   output logic            sd_oe,
   output logic [7:0]      rd_byte,
   output logic            rd_stb
);
   // ****************************************************************
   // Three-wire mode 3 master, clock still outside frames
   // ****************************************************************
   localparam int HALF = 80;

   initial
   begin
      sclk    = 1'b1;
      cs_n    = 1'b1;
      sd_out  = 1'b0;
      sd_oe   = 1'b0;
      rd_byte = 8'h00;
      rd_stb  = 1'b0;
   end

   task automatic xfer(input logic rd, input logic [6:0] ad, input int n, input logic [7:0] wd);
      logic [7:0] hdr;
      logic [7:0] sh;
      hdr  = {rd, ad};
      sh   = 8'h00;
      cs_n = 1'b0;
      #HALF;
      for (int i = 7; i >= 0; i--)
      begin
         sclk   = 1'b0;
         sd_oe  = 1'b1;
         sd_out = hdr[i];
         #HALF;
         sclk = 1'b1;
         #HALF;
      end
      for (int b = 0; b < n; b++)
      begin
         for (int i = 7; i >= 0; i--)
         begin
            // Released on the first data fall of a read
            sclk   = 1'b0;
            sd_oe  = !rd;
            sd_out = wd[i];
            #HALF;
            sclk = 1'b1;
            sh   = {sh[6:0], sd_wire};
            #HALF;
         end
         if (rd)
         begin
            rd_byte = sh;
            rd_stb  = ~rd_stb;
         end
      end
      cs_n  = 1'b1;
      sd_oe = 1'b0;
      #(4 * HALF);
   endtask
endmodule // asp_aux_master
`default_nettype wire

// ### sim/tb_aux_spi_ois_gyro_port.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_aux_spi_ois_gyro_port
   import asp_pkg::*;
;
   // ****************************************************************
   // Stimulus and observation
   // ****************************************************************
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        prim_req = 1'b0;
   logic        prim_we = 1'b0;
   logic [6:0]  prim_addr = 7'h00;
   logic [7:0]  prim_wdata = 8'h00;
   logic [7:0]  prim_rdata;
   logic        prim_rvalid;
   logic [47:0] prim_gyro_data = 48'h0000_0000_0000;
   logic [7:0]  prim_status = 8'h00;
   logic [15:0] fifo_data = 16'h0000;
   logic [47:0] ois_gyro_data = 48'h0000_0000_0000;
   logic        ois_gyro_valid = 1'b0;
   logic        gyro_settling = 1'b0;
   logic        sclk, cs_n, m_sd, m_oe, dut_sd, dut_oe, aux_stb;
   logic        float_v = 1'b0;
   logic        aux_mode_active, gyro_new_sample_flag;
   logic [7:0]  aux_byte, tp, ta, v, d;
   logic [6:0]  a;
   logic        seen = 1'b0;
   logic [7:0]  exp_p[$];
   logic [7:0]  exp_a[$];
   logic [7:0]  vals [5] = '{8'h00, 8'h01, 8'h20, 8'hff, 8'h21};
   int          n_fail = 0;
   int          checks = 0;
   int          cyc = 0;
   wire logic   sd_wire;

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) float_v <= ~float_v;
   assign sd_wire = dut_oe ? dut_sd : (m_oe ? m_sd : float_v);

   asp_aux_spi_ois_gyro_port DUT
   (
      .core_clk                (core_clk),
      .arst_n                  (arst_n),
      .prim_req                (prim_req),
      .prim_we                 (prim_we),
      .prim_addr               (prim_addr),
      .prim_wdata              (prim_wdata),
      .prim_rdata              (prim_rdata),
      .prim_rvalid             (prim_rvalid),
      .prim_gyro_data          (prim_gyro_data),
      .prim_status             (prim_status),
      .fifo_data               (fifo_data),
      .ois_gyro_data           (ois_gyro_data),
      .ois_gyro_valid          (ois_gyro_valid),
      .gyro_settling           (gyro_settling),
      .aux_serial_clock_pin    (sclk),
      .aux_cs_n_pin            (cs_n),
      .aux_serial_data_pin_in  (sd_wire),
      .aux_serial_data_pin_out (dut_sd),
      .aux_serial_data_pin_oe  (dut_oe),
      .aux_mode_active         (aux_mode_active),
      .gyro_new_sample_flag    (gyro_new_sample_flag)
   );

   asp_aux_master m
   (
      .sd_wire (sd_wire),
      .sclk    (sclk),
      .cs_n    (cs_n),
      .sd_out  (m_sd),
      .sd_oe   (m_oe),
      .rd_byte (aux_byte),
      .rd_stb  (aux_stb)
   );

   always @(negedge core_clk)
      if (prim_rvalid === 1'b1)
      begin
         tp = exp_p.pop_front();
         `CHK(prim_rdata, tp)
      end

   always @(aux_stb)
      if (arst_n === 1'b1)
      begin
         ta = exp_a.pop_front();
         `CHK(aux_byte, ta)
      end

   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         $display("unexpected at %0t: run did not finish", $time);
         test_done();
      end
   end

   task automatic prim(input logic we, input logic [6:0] ad, input logic [7:0] wd, input logic [7:0] e);
      if (!we)
         exp_p.push_back(e);
      prim_req   = 1'b1;
      prim_we    = we;
      prim_addr  = ad;
      prim_wdata = wd;
      @(posedge core_clk);
      #1;
   endtask

   task automatic idle(input int n);
      prim_req = 1'b0;
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic aux(input logic rd, input logic [6:0] ad, input int n, input logic [7:0] wd);
      m.xfer(rd, ad, n, wd);
      @(posedge core_clk);
      #1;
   endtask

   task automatic pulse;
      ois_gyro_valid = 1'b1;
      @(posedge core_clk);
      #1;
      ois_gyro_valid = 1'b0;
      idle(3);
   endtask

   task automatic tend(input string s);
      $display("test %s done", s);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      void'($urandom(83984));
      prim_gyro_data = {16'($urandom()), 32'($urandom())};
      prim_status    = 8'($urandom());
      fifo_data      = 16'($urandom());
      repeat (12) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      // Host write of 8'hff to aux control is ignored; control reads 0, status passes through
      idle(3);
      prim(1'b1, 7'h70, 8'hff, 8'h00);
      prim(1'b0, 7'h70, 8'h00, 8'h00);
      prim(1'b0, 7'h1e, 8'h00, prim_status);
      idle(2);
      tend("reset");
      foreach (vals[i])
      begin
         v             = vals[i];
         ois_gyro_data = {16'($urandom()), 32'($urandom())};
         aux(1'b0, 7'h70, 1, v);
         `CHK(aux_mode_active, v[5] & v[0])
         pulse();
         seen = seen | (v[5] & v[0]);
         `CHK(gyro_new_sample_flag, seen)
         prim(1'b0, 7'h70, 8'h00, v & 8'ha1);
         idle(2);
      end
      tend("mode");
      for (int i = 0; i < 6; i++)
         exp_a.push_back(ois_gyro_data[8*i +: 8]);
      aux(1'b1, 7'h22, 6, 8'h00);
      `CHK(gyro_new_sample_flag, 1'b0)
      for (int i = 0; i < 6; i++)
         prim(1'b0, 7'(8'h22 + i), 8'h00, prim_gyro_data[8*i +: 8]);
      idle(2);
      pulse();
      exp_a.push_back(ois_gyro_data[7:0]);
      aux(1'b1, 7'h22, 1, 8'h00);
      prim(1'b0, 7'h23, 8'h00, prim_gyro_data[15:8]);
      idle(2);
      `CHK(gyro_new_sample_flag, 1'b1)
      aux(1'b0, 7'h70, 1, 8'ha1);
      ois_gyro_data = {16'($urandom()), 32'($urandom())};
      pulse();
      exp_a.push_back(ois_gyro_data[15:8]);
      exp_a.push_back(ois_gyro_data[7:0]);
      aux(1'b1, 7'h22, 2, 8'h00);
      `CHK(gyro_new_sample_flag, 1'b0)
      tend("gyro");
      gyro_settling = 1'b1;
      idle(4);
      exp_a.push_back(8'h04);
      aux(1'b1, 7'h1e, 1, 8'h00);
      gyro_settling = 1'b0;
      pulse();
      exp_a.push_back(8'h02);
      aux(1'b1, 7'h1e, 1, 8'h00);
      tend("status");
      prim(1'b0, 7'h3e, 8'h00, fifo_data[7:0]);
      prim(1'b0, 7'h3f, 8'h00, fifo_data[15:8]);
      idle(2);
      exp_a.push_back(8'h00);
      aux(1'b1, 7'h3e, 1, 8'h00);
      tend("fifo");
      repeat (3)
      begin
         a = 7'($urandom_range(64, 111));
         d = 8'($urandom());
         prim(1'b1, a, d, 8'h00);
         idle(2);
         aux(1'b0, a, 1, ~d);
         exp_a.push_back(d);
         fork
            aux(1'b1, a, 1, 8'h00);
            begin
               repeat (260) prim(1'b0, a, 8'h00, d);
               idle(2);
            end
         join
      end
      tend("shared");
      idle(4);
      `CHK(exp_p.size() + exp_a.size(), 0)
      test_done();
   end
endmodule // tb_aux_spi_ois_gyro_port
`default_nettype wire
